// File: design/sdwl_loader.sv
`timescale 1ns/10ps
`default_nettype none
module sdwl_loader #(
	parameter bit LOAD_PIN = 1'b1
) (
	// System clock, reset, enable
	input  wire logic                      clk_i,
	input  wire logic                      rst_b_i,
	input  wire logic                      ce_i,
	// Serial link
	input  wire logic                      link_sclk_i,
	input  wire logic                      frame_sel_n_i,
	input  wire logic                      serial_data_in_i,
	input  wire logic                      latch_load_n_i,
	// Converter side
	input  wire logic                      settle_busy_i,
	output logic [sdwl_pkg::WORD_W-1:0]    analog_code_o,
	output logic [sdwl_pkg::SEG_N-1:0]     segment_switches_o,
	output logic [sdwl_pkg::LAD_W-1:0]     ladder_switches_o,
	// Status
	output logic                           word_space_o,
	output logic                           update_pending_o
);
	import sdwl_pkg::*;

	sdwl_word_t        shift_q;
	logic [2:0]        cs_sync;
	logic [2:0]        ld_sync;
	logic              cs_high;
	logic              ld_low;
	logic              push;
	logic              fifo_in_ready;
	logic              fifo_out_valid;
	sdwl_word_t        fifo_out_data;
	logic              in_load;
	sdwl_word_t        input_reg;
	sdwl_word_t        latch_q;
	sdwl_word_t        next_latch;
	sdwl_drive_t       drive_q;
	sdwl_latch_state_t lstate;
	sdwl_latch_state_t next_lstate;

	////////////////////////////////////////////////////////////////////////////////
	// Link domain: shift register on the serial clock

	// No reset here: the serial clock may never run while reset is applied
	always_ff @(posedge link_sclk_i)
	begin
		if (!frame_sel_n_i)
		begin
			shift_q <= {shift_q[WORD_W-2:0], serial_data_in_i};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers, three stages each

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			cs_sync <= 3'h7;
			ld_sync <= 3'h7;
		end
		else if (ce_i)
		begin
			cs_sync <= {cs_sync[1:0], frame_sel_n_i};
			ld_sync <= {ld_sync[1:0], latch_load_n_i};
		end
	end

	// A change counts only once stages two and three agree
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			cs_high <= 1'b1;
			ld_low  <= 1'b0;
		end
		else if (ce_i)
		begin
			if (cs_sync[1] == cs_sync[2])
			begin
				cs_high <= cs_sync[2];
			end
			if (ld_sync[1] == ld_sync[2])
			begin
				ld_low <= LOAD_PIN && !ld_sync[2];
			end
		end
	end

	// Frame close: shift register is static once the serial clock is ignored
	assign push = ce_i && cs_sync[1] && cs_sync[2] && !cs_high;

	////////////////////////////////////////////////////////////////////////////////
	// Word buffer between frame close and input register

	sdwl_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_b_i     (rst_b_i),
		.ce_i        (ce_i),
		.in_valid_i  (push),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (shift_q),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (!settle_busy_i),
		.out_data_o  (fifo_out_data)
	);

	// Settling stalls the drain, so the buffer can really fill
	assign in_load = ce_i && fifo_out_valid && !settle_busy_i;

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			input_reg <= CODE_ZERO;
		end
		else if (in_load)
		begin
			input_reg <= fifo_out_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Converter latch control

	always_comb
	begin
		next_lstate = lstate;
		case (lstate)
			LS_IDLE:
			begin
				if (ld_low && cs_high)
					next_lstate = LS_FOLLOW;
				else if (in_load && LOAD_PIN)
					next_lstate = LS_HOLD;
			end
			LS_HOLD:
			begin
				if (ld_low && cs_high)
					next_lstate = LS_FOLLOW;
			end
			LS_FOLLOW:
			begin
				if (!(ld_low && cs_high))
					next_lstate = in_load ? LS_HOLD : LS_IDLE;
			end
			default:
			begin
				next_lstate = LS_IDLE;
			end
		endcase
	end

	always_comb
	begin
		next_latch = latch_q;
		if (!LOAD_PIN)
		begin
			if (in_load)
				next_latch = fifo_out_data;
		end
		else if (lstate == LS_FOLLOW)
		begin
			next_latch = input_reg;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			lstate <= LS_IDLE;
		end
		else if (ce_i)
		begin
			lstate <= next_lstate;
		end
	end

	// Switch controls registered with the latch so they never lag it
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			latch_q <= CODE_ZERO;
			drive_q <= sdwl_decode(CODE_ZERO);
		end
		else if (ce_i)
		begin
			latch_q <= next_latch;
			drive_q <= sdwl_decode(next_latch);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			word_space_o     <= 1'b1;
			update_pending_o <= 1'b0;
		end
		else if (ce_i)
		begin
			word_space_o     <= fifo_in_ready;
			update_pending_o <= (next_lstate == LS_HOLD);
		end
	end

	assign analog_code_o      = latch_q;
	assign segment_switches_o = drive_q.seg;
	assign ladder_switches_o  = drive_q.ladder;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	AST_SHIFT_MSB_FIRST: assert property (@(posedge link_sclk_i) disable iff (!rst_b_i)
		!frame_sel_n_i |=> shift_q[0] == $past(serial_data_in_i))
		else $error("framed rising edge did not sample data into bit 0");

	AST_KEEP_LAST_BITS: assert property (@(posedge link_sclk_i) disable iff (!rst_b_i)
		!frame_sel_n_i |=> shift_q[WORD_W-1:1] === $past(shift_q[WORD_W-2:0]))
		else $error("older bits not moved up by one");

	AST_IGNORE_UNFRAMED: assert property (@(posedge link_sclk_i) disable iff (!rst_b_i)
		frame_sel_n_i |=> $stable(shift_q))
		else $error("shift register moved while frame select high");

	AST_RESET_ZERO: assert property (@(posedge clk_i)
		!rst_b_i |=> latch_q == CODE_ZERO && input_reg == CODE_ZERO && analog_code_o == CODE_ZERO)
		else $error("registers not zero after reset");

	AST_ZERO_HELD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		input_reg == CODE_ZERO && !in_load |=> input_reg == CODE_ZERO)
		else $error("input register left zero without a load");

	AST_FRAME_TO_INPUT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		push && fifo_in_ready && !fifo_out_valid && !settle_busy_i ##1 ce_i && !settle_busy_i
		|=> input_reg == $past(shift_q, 2))
		else $error("closed frame did not reach the input register");

	AST_DIRECT_UPDATE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!LOAD_PIN && in_load |=> latch_q == input_reg)
		else $error("latch did not load with the input register");

	AST_FOLLOW_LOW: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && lstate == LS_FOLLOW |=> latch_q == $past(input_reg))
		else $error("latch did not follow input register");

	AST_HOLD_WHILE_HIGH: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		LOAD_PIN && lstate != LS_FOLLOW |=> $stable(latch_q))
		else $error("latch changed without a load strobe");

	AST_TIED_LOW_UPDATE: assert property (@(posedge clk_i) disable iff (!rst_b_i || !ce_i)
		LOAD_PIN && ld_low && cs_high && in_load
		|-> ##2 latch_q == $past(input_reg))
		else $error("tied-low load did not update latch in two cycles");

	AST_SWITCH_DECODE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i |=> segment_switches_o == sdwl_thermo(analog_code_o[MSB_POS -: MSB_W])
			&& ladder_switches_o == analog_code_o[LAD_TOP:0])
		else $error("switch controls disagree with latch code");

	COV_FRAME_CLOSE: cover property (@(posedge clk_i) disable iff (!rst_b_i) push);
	COV_DEFERRED_LOAD: cover property (@(posedge clk_i) disable iff (!rst_b_i)
		lstate == LS_HOLD ##[1:200] lstate == LS_FOLLOW);
	COV_BUFFER_FULL: cover property (@(posedge clk_i) disable iff (!rst_b_i) !fifo_in_ready);
	COV_FULL_SCALE: cover property (@(posedge clk_i) disable iff (!rst_b_i) analog_code_o == 16'hffff);

endmodule // sdwl_loader
`default_nettype wire

// File: shared/sdwl_pkg.sv
`default_nettype none
package sdwl_pkg;

	localparam int WORD_W     = 16;
	localparam int MSB_W      = 4;
	localparam int SEG_N      = 15;
	localparam int LAD_W      = 12;
	localparam int FIFO_DEPTH = 16;
	localparam int MSB_POS    = 15;
	localparam int LAD_TOP    = 11;

	// Latch code zero gives zero output; the full span is 65536 steps
	localparam logic [WORD_W-1:0] CODE_ZERO = 16'h0000;
	localparam logic [WORD_W:0]   CODE_SPAN = 17'h10000;

	// Link limits, in their own units
	localparam int LINK_MAX_MBPS = 50;
	localparam int CLK_MHZ       = 50;

	typedef logic [WORD_W-1:0] sdwl_word_t;

	typedef struct packed
	{
		logic [SEG_N-1:0] seg;
		logic [LAD_W-1:0] ladder;
	} sdwl_drive_t;

	typedef enum logic [1:0]
	{
		LS_IDLE   = 2'b00,
		LS_HOLD   = 2'b01,
		LS_FOLLOW = 2'b10
	} sdwl_latch_state_t;

	// Top code bits to a thermometer of segment controls
	function automatic logic [SEG_N-1:0] sdwl_thermo(input logic [MSB_W-1:0] top);
		logic [SEG_N-1:0] t;
		t = '0;
		for (int i = 0; i < SEG_N; i++)
		begin
			t[i] = (32'(top) > i);
		end
		return t;
	endfunction

	function automatic sdwl_drive_t sdwl_decode(input sdwl_word_t code);
		sdwl_drive_t d;
		d.seg    = sdwl_thermo(code[MSB_POS -: MSB_W]);
		d.ladder = code[LAD_TOP:0];
		return d;
	endfunction

endpackage
`default_nettype wire

// File: design/sdwl_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module sdwl_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	input  wire logic             ce_i,
	// Fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             do_push;
	logic             do_pop;

	assign in_ready_o  = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o  = mem[rd_ptr];
	assign do_push     = ce_i && in_valid_i && in_ready_o;
	assign do_pop      = ce_i && out_valid_o && out_ready_i;

	// Storage needs no reset; only the pointers and count define what is valid
	always_ff @(posedge clk_i)
	begin
		if (do_push)
		begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			if (do_push)
			begin
				wr_ptr <= AW'(wr_ptr + 1'b1);
			end
			if (do_pop)
			begin
				rd_ptr <= AW'(rd_ptr + 1'b1);
			end
			if (do_push && !do_pop)
			begin
				count <= (AW+1)'(count + 1'b1);
			end
			else if (do_pop && !do_push)
			begin
				count <= (AW+1)'(count - 1'b1);
			end
		end
	end

endmodule // sdwl_fifo
`default_nettype wire

// File: tb/sdwl_master.sv
`timescale 1ns/10ps
`default_nettype none
module sdwl_master
(
	// Serial link
	output logic sclk_o,
	output logic frame_sel_n_o,
	output logic serial_data_o
);
	initial
	begin
		sclk_o        = 1'b0;
		frame_sel_n_o = 1'b1;
		serial_data_o = 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// One framed transfer, n bits of w, MSB first
	task automatic send(input logic [31:0] w, input int n);
		frame_sel_n_o = 1'b0;
		#10;
		for (int i = n - 1; i >= 0; i--)
		begin
			serial_data_o = w[i];
			#7.5 sclk_o = 1'b1;
			#7.5 sclk_o = 1'b0;
		end
		#10 frame_sel_n_o = 1'b1;
		// Released line must not keep showing the last bit
		serial_data_o = ~serial_data_o;
		// Gap above five system clocks so the word is captured
		#200;
	endtask

	////////////////////////////////////////////////////////////////
	// Clocks with the frame closed; a selected device would take them
	task automatic stray(input int n);
		for (int i = 0; i < n; i++)
		begin
			serial_data_o = ~serial_data_o;
			#7.5 sclk_o = 1'b1;
			#7.5 sclk_o = 1'b0;
		end
		#200;
	endtask
endmodule // sdwl_master
`default_nettype wire

// File: tb/sdwl_loader_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sdwl_loader_tb;
	import sdwl_pkg::*;
	logic              clk, rst_b, ce, busy, ld_n, sclk, fs_n, sdata;
	logic [WORD_W-1:0] code1, code0, held;
	logic [SEG_N-1:0]  seg1, seg0;
	logic [LAD_W-1:0]  lad1, lad0;
	logic              space1, space0, pend1, pend0;
	int                err_total, tests_run, cyc;

	sdwl_master m (.sclk_o(sclk), .frame_sel_n_o(fs_n), .serial_data_o(sdata));
	sdwl_loader #(.LOAD_PIN(1'b1)) dut (.clk_i(clk), .rst_b_i(rst_b), .ce_i(ce), .link_sclk_i(sclk),
		.frame_sel_n_i(fs_n), .serial_data_in_i(sdata), .latch_load_n_i(ld_n), .settle_busy_i(busy),
		.analog_code_o(code1), .segment_switches_o(seg1), .ladder_switches_o(lad1),
		.word_space_o(space1), .update_pending_o(pend1));
	sdwl_loader #(.LOAD_PIN(1'b0)) dut0 (.clk_i(clk), .rst_b_i(rst_b), .ce_i(ce), .link_sclk_i(sclk),
		.frame_sel_n_i(fs_n), .serial_data_in_i(sdata), .latch_load_n_i(ld_n), .settle_busy_i(busy),
		.analog_code_o(code0), .segment_switches_o(seg0), .ladder_switches_o(lad0),
		.word_space_o(space0), .update_pending_o(pend0));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Run should take under two thousand cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			err_total++;
			results();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	function automatic logic [14:0] therm(input logic [3:0] t);
		logic [14:0] r;
		for (int i = 0; i < 15; i++)
			r[i] = (t > i);
		return r;
	endfunction

	task automatic chk_out(input logic [15:0] e0, input logic [15:0] e1);
		chk(code0, e0);
		chk({1'b0, seg0}, {1'b0, therm(e0[15:12])});
		chk({4'h0, lad0}, {4'h0, e0[11:0]});
		chk(code1, e1);
		chk({1'b0, seg1}, {1'b0, therm(e1[15:12])});
		chk({4'h0, lad1}, {4'h0, e1[11:0]});
	endtask

	task automatic frame(input logic [31:0] w, input int n);
		m.send(w, n);
		repeat (12) @(negedge clk);
	endtask

	task automatic t_reset;
		chk_out(16'h0000, 16'h0000);
		chk({15'h0, space1}, 16'h0001);
		chk({15'h0, pend1}, 16'h0000);
		chk({15'h0, pend0}, 16'h0000);
	endtask

	task automatic t_deferred;
		frame(32'h0000_a5c3, 16);
		chk_out(16'ha5c3, 16'h0000);
		chk({15'h0, pend1}, 16'h0001);
		ld_n = 1'b0;
		repeat (8) @(negedge clk);
		ld_n = 1'b1;
		repeat (4) @(negedge clk);
		chk_out(16'ha5c3, 16'ha5c3);
		chk({15'h0, pend1}, 16'h0000);
		frame(32'h0000_3c5a, 16);
		chk_out(16'h3c5a, 16'ha5c3);
	endtask

	task automatic t_sizes;
		frame(32'h000f_1234, 20);
		chk_out(16'h1234, 16'ha5c3);
		m.stray(5);
		frame(32'h0000_0096, 8);
		chk_out(16'h3496, 16'ha5c3);
	endtask

	task automatic t_follow;
		logic [15:0] w;
		ld_n = 1'b0;
		for (int t = 0; t < 16; t++)
		begin
			w = {4'(t), ~{3{4'(t)}}};
			frame({16'h0, w}, 16);
			chk_out(w, w);
		end
		frame(32'h0000_ffff, 16);
		chk_out(16'hffff, 16'hffff);
		frame(32'h0, 16);
		chk_out(CODE_ZERO, CODE_ZERO);
	endtask

	task automatic t_fifo;
		held = code0;
		busy = 1'b1;
		for (int i = 0; i < 17; i++)
			frame(32'h1000 + 32'(i), 16);
		chk({15'h0, space0}, 16'h0000);
		chk_out(held, held);
		busy = 1'b0;
		repeat (80) @(negedge clk);
		chk_out(16'h100f, 16'h100f);
		chk({15'h0, space0}, 16'h0001);
	endtask

	// Frozen block misses the frame; shift register survives a mid-run reset
	task automatic t_enable;
		ce = 1'b0;
		frame(32'h0000_5555, 16);
		chk_out(16'h100f, 16'h100f);
		ce = 1'b1;
		repeat (4) @(negedge clk);
		chk_out(16'h100f, 16'h100f);
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		@(negedge clk);
		chk_out(16'h0000, 16'h0000);
		frame(32'h0000_00ab, 8);
		chk_out(16'h55ab, 16'h55ab);
	endtask

	initial
	begin
		rst_b = 1'b0;
		ce = 1'b1;
		busy = 1'b0;
		ld_n = 1'b1;
		err_total = 0;
		tests_run = 0;
		cyc = 0;
		repeat (20) @(negedge clk);
		rst_b = 1'b1;
		@(negedge clk);
		t_reset();
		t_deferred();
		t_sizes();
		t_follow();
		t_fifo();
		t_enable();
		results();
	end
endmodule // sdwl_loader_tb
`default_nettype wire
